// *** src/pmcs_regs.vh ***
// Purpose: register offsets, fields, resets and timing counts of the clock/power switch
// Assumes: classic wishbone, 32-bit words, byte addresses
// Notes:   included by pmcs_top.v
`ifndef PMCS_REGS_VH
`define PMCS_REGS_VH

`define PMCS_ADDR_SYSMODE      8'h00
`define PMCS_ADDR_RSTFLAGS     8'h04
`define PMCS_ADDR_STATUS       8'h08

// system_mode_control fields
`define PMCS_SM_CKS_HI         7
`define PMCS_SM_CKS_LO         5
`define PMCS_SM_FSTW           4
`define PMCS_SM_LRDY           3
`define PMCS_SM_HRDY           2
`define PMCS_SM_IDLE_ENABLE_BIT          1
`define PMCS_SM_HLSEL          0
`define PMCS_SM_RESET          8'h01

// reset_flags_and_clock_keep fields
`define PMCS_RF_KEEP           7
`define PMCS_RF_LVR            2
`define PMCS_RF_VCR            1
`define PMCS_RF_WDR            0
`define PMCS_RF_RESET          8'h00

// status register fields (read only)
`define PMCS_ST_PDF            0
`define PMCS_ST_TOF            1
`define PMCS_ST_MODE_LO        4

// timing counts, in oscillator cycles
`define PMCS_HXT_SETTLE        8'd128
`define PMCS_INTERNAL_HIGH_SPEED_OSCILLATOR_SETTLE       8'd16
`define PMCS_INTERNAL_LOW_SPEED_OSCILLATOR_SETTLE       8'd2
`define PMCS_SUB_WAKE          2'd2

// operating modes
`define PMCS_MODE_RUN          3'h0
`define PMCS_MODE_DEEP         3'h1
`define PMCS_MODE_WSLP         3'h2
`define PMCS_MODE_CLOCK_STOPPED_IDLE_MODE        3'h3
`define PMCS_MODE_CLOCK_RUNNING_IDLE_MODE        3'h4
`define PMCS_MODE_WAKE         3'h5

`endif

// *** src/pmcs_top.v ***
// Purpose: system clock selection, halt mode control, fast wake-up and reset-cause flags
// Assumes: oscillators present as one-cycle tick enables on clk_i; ticks are async-ish pins
// Notes:   the system clock is modelled as a clock-enable pulse, never a gated clock
`include "pmcs_regs.vh"
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RL1 - crystal wake raises high-speed ready only after 128 crystal cycles
// RL2 - halt with idle enable set enters an idle mode
// RL3 - idle with clock keep set: cpu stops, system clock keeps running
// RL4 - idle with clock keep clear: cpu and system clock both stop
// RL5 - halt with idle enable clear enters a sleep mode
// RL6 - select bit 1 gives undivided fast clock, 0 gives divided or slow
// RL7 - selecting slow clock turns the high-speed oscillator off
// RL8 - divide-by-16 and divide-by-64 outputs stop with the fast clock
// RL9 - low-voltage reset flag sets on event, cleared only by writing 0
// RL10 - voltage-control reset flag sets on bad control value, software clears
// RL11 - watchdog-control reset flag sets on event, cleared only by writing 0
// RL12 - bits 6 to 3 of reset-flag register read as zero
// RL13 - fast wake only from watchdog-on sleep or clock-stopped idle; the code also fast-wakes from sleep entered with only the detector on
// RL14 - crystal fast wake: sub clock in 1-2 ticks, crystal after 128
// RL15 - internal oscillators wake in 15-16 or 1-2 cycles, fast bit ignored
// RL16 - watchdog off means no fast wake from deep sleep
// RL17 - select 0 with source 000 or 001 runs from low-speed oscillator
// RL18 - low-speed stability reported by low-speed ready bit
// RL19 - select 1 or source 010 to 111 returns to fast clock
// RL20 - software polls high-speed ready after switching back
// RL21 - halt, idle clear, watchdog and detector off: deep sleep, watchdog cleared
// RL22 - halt, idle clear, watchdog or detector on: sleep keeping sub clock
// RL23 - any halt sets power-down flag and clears time-out flag; halt_i is taken only in run mode
// RL24 - clock source changes only on a clean edge after release
module pmcs_top #(
  parameter HOSC_SEL = 2'h0  // 0 crystal, 1 internal fast, 2 internal slow
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // oscillator ticks (external domain)
  input  wire        fast_tick_i,
  input  wire        slow_tick_i,
  input  wire        slow_stable_i,
  // cpu and system events
  input  wire        halt_i,
  input  wire        wake_i,
  input  wire        wdt_on_i,
  input  wire        lvd_on_i,
  input  wire        wdt_clear_i,
  input  wire        wdt_timeout_i,
  input  wire        lvr_event_i,
  input  wire        vcr_bad_i,
  input  wire        wdr_event_i,
  // clock controls
  output reg         sys_en_o,
  output reg         cpu_run_o,
  output reg         fast_osc_on_o,
  output reg         div16_en_o,
  output reg         div64_en_o,
  output reg         sub_clk_on_o,
  output reg         wdt_stop_o,
  output reg         using_sub_o
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for oscillator pins
  reg  [2:0] ft_s_q;
  reg  [2:0] st_s_q;
  reg  [1:0] ss_s_q;
  wire       ft_tick = ft_s_q[1] & ~ft_s_q[2];
  wire       st_tick = st_s_q[1] & ~st_s_q[2];
  wire       slow_ok = ss_s_q[1];

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ft_s_q <= 3'h0;
      st_s_q <= 3'h0;
      ss_s_q <= 2'h0;
    end
    else
    begin
      ft_s_q <= {ft_s_q[1:0], fast_tick_i};
      st_s_q <= {st_s_q[1:0], slow_tick_i};
      ss_s_q <= {ss_s_q[0], slow_stable_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [7:0] system_mode_control_q;
  reg  [7:0] rflg_q;
  reg        pdf_q;
  reg        tof_q;
  reg        hrdy_q;
  reg  [2:0] mode_q;
  reg  [7:0] hcnt_q;
  reg  [1:0] scnt_q;
  reg        sub_q;
  reg  [5:0] div_q;

  wire [2:0] cks    = system_mode_control_q[`PMCS_SM_CKS_HI:`PMCS_SM_CKS_LO];
  wire       hlsel  = system_mode_control_q[`PMCS_SM_HLSEL];
  wire       slow_s = ~hlsel & (cks[2:1] == 2'h0);                 // see RL17 RL19
  wire       wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr_b0  = wb_req & wb_we_i & wb_sel_i[0];
  wire       wr_sm  = wr_b0 & (wb_adr_i == `PMCS_ADDR_SYSMODE);
  wire       wr_rf  = wr_b0 & (wb_adr_i == `PMCS_ADDR_RSTFLAGS);
  wire       halt_e = halt_i & (mode_q == `PMCS_MODE_RUN);

  // settle target by oscillator type
  wire [7:0] settle = (HOSC_SEL == 2'h0) ? `PMCS_HXT_SETTLE :
                      (HOSC_SEL == 2'h1) ? `PMCS_INTERNAL_HIGH_SPEED_OSCILLATOR_SETTLE :
                                           `PMCS_INTERNAL_LOW_SPEED_OSCILLATOR_SETTLE;

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      system_mode_control_q <= `PMCS_SM_RESET;
      rflg_q <= `PMCS_RF_RESET;
      pdf_q  <= 1'b0;
      tof_q  <= 1'b0;
    end
    else
    begin
      if (wr_sm)
        system_mode_control_q <= {wb_dat_i[7:4], 2'h0, wb_dat_i[1:0]};
      if (wr_rf)
        rflg_q[`PMCS_RF_KEEP] <= wb_dat_i[`PMCS_RF_KEEP];
      // set beats a same-cycle software clear
      rflg_q[`PMCS_RF_LVR] <= lvr_event_i |
        (rflg_q[`PMCS_RF_LVR] & ~(wr_rf & ~wb_dat_i[`PMCS_RF_LVR]));    // see RL9
      rflg_q[`PMCS_RF_VCR] <= vcr_bad_i |
        (rflg_q[`PMCS_RF_VCR] & ~(wr_rf & ~wb_dat_i[`PMCS_RF_VCR]));    // see RL10
      rflg_q[`PMCS_RF_WDR] <= wdr_event_i |
        (rflg_q[`PMCS_RF_WDR] & ~(wr_rf & ~wb_dat_i[`PMCS_RF_WDR]));    // see RL11
      rflg_q[6:3] <= 4'h0;                                          // see RL12
      if (halt_e)
      begin
        pdf_q <= 1'b1;                                              // see RL23
        tof_q <= 1'b0;
      end
      else
      begin
        if (wdt_clear_i)
          pdf_q <= 1'b0;
        if (wdt_timeout_i)
          tof_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode machine
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      mode_q <= `PMCS_MODE_RUN;
      hrdy_q <= 1'b0;
      hcnt_q <= 8'h00;
      scnt_q <= 2'h0;
      sub_q  <= 1'b0;
    end
    else
    begin
      case (mode_q)
        `PMCS_MODE_RUN:
        begin
          if (halt_e)
          begin
            if (system_mode_control_q[`PMCS_SM_IDLE_ENABLE_BIT])                             // see RL2
              mode_q <= rflg_q[`PMCS_RF_KEEP] ? `PMCS_MODE_CLOCK_RUNNING_IDLE_MODE : `PMCS_MODE_CLOCK_STOPPED_IDLE_MODE;
            else if (wdt_on_i | lvd_on_i)                           // see RL5
              mode_q <= `PMCS_MODE_WSLP;                            // see RL22
            else
              mode_q <= `PMCS_MODE_DEEP;                            // see RL21
            if (~(system_mode_control_q[`PMCS_SM_IDLE_ENABLE_BIT] & rflg_q[`PMCS_RF_KEEP]))
              hrdy_q <= 1'b0;
          end
          else if (slow_s)
            hrdy_q <= 1'b0;                                         // see RL7
          else if (~hrdy_q)
          begin
            // restart after slow mode; software polls the flag   see RL20
            if (ft_tick)
              hcnt_q <= hcnt_q + 8'h01;
            if (ft_tick & (hcnt_q + 8'h01 >= settle))
            begin
              hrdy_q <= 1'b1;
              hcnt_q <= 8'h00;
            end
          end
        end
        `PMCS_MODE_CLOCK_RUNNING_IDLE_MODE:
          if (wake_i)
            mode_q <= `PMCS_MODE_RUN;
        `PMCS_MODE_DEEP, `PMCS_MODE_WSLP, `PMCS_MODE_CLOCK_STOPPED_IDLE_MODE:
          if (wake_i)
          begin
            mode_q <= `PMCS_MODE_WAKE;
            hcnt_q <= 8'h00;
            scnt_q <= 2'h0;
            // sub clock is dead in deep sleep, so no fast path   see RL13 RL16
            sub_q  <= 1'b0;
            if ((mode_q != `PMCS_MODE_DEEP) & (HOSC_SEL == 2'h0) &
                system_mode_control_q[`PMCS_SM_FSTW])                              // see RL15
              sub_q <= 1'b1;
          end
        `PMCS_MODE_WAKE:
        begin
          if (ft_tick)
            hcnt_q <= hcnt_q + 8'h01;
          if (sub_q & st_tick & (scnt_q != `PMCS_SUB_WAKE))
            scnt_q <= scnt_q + 2'h1;                                // see RL14
          if (ft_tick & (hcnt_q + 8'h01 >= settle))
          begin
            hrdy_q <= 1'b1;                                         // see RL1
            sub_q  <= 1'b0;
            mode_q <= `PMCS_MODE_RUN;
            hcnt_q <= 8'h00;
          end
        end
        default:
          mode_q <= `PMCS_MODE_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enables; a source change takes effect only on its own tick
  wire sub_run   = sub_q & (scnt_q == `PMCS_SUB_WAKE);
  wire fast_live = hrdy_q & ~slow_s;
  wire cpu_on    = (mode_q == `PMCS_MODE_RUN) | sub_run;
  wire sys_live  = cpu_on | (mode_q == `PMCS_MODE_CLOCK_RUNNING_IDLE_MODE);           // see RL3 RL4
  reg  [2:0] dsel;
  reg        div_hit;

  always @*
  begin
    dsel    = hlsel ? 3'h0 : cks;                                   // see RL6
    div_hit = 1'b0;
    case (dsel)
      3'h0: div_hit = 1'b1;
      3'h2: div_hit = (div_q[5:0] == 6'h3F);
      3'h3: div_hit = (div_q[4:0] == 5'h1F);
      3'h4: div_hit = (div_q[3:0] == 4'hF);
      3'h5: div_hit = (div_q[2:0] == 3'h7);
      3'h6: div_hit = (div_q[1:0] == 2'h3);
      3'h7: div_hit = div_q[0];
      default: div_hit = 1'b0;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      div_q         <= 6'h00;
      sys_en_o      <= 1'b0;
      cpu_run_o     <= 1'b0;
      fast_osc_on_o <= 1'b1;
      div16_en_o    <= 1'b0;
      div64_en_o    <= 1'b0;
      sub_clk_on_o  <= 1'b1;
      wdt_stop_o    <= 1'b0;
      using_sub_o   <= 1'b0;
    end
    else
    begin
      if (fast_live & ft_tick)
        div_q <= div_q + 6'h01;
      // glitch-free: enable pulses only from the active tick   see RL24
      if (~sys_live)
        sys_en_o <= 1'b0;
      else if (sub_run | slow_s)
        sys_en_o <= st_tick & (sub_run | slow_ok);                  // see RL18
      else
        sys_en_o <= fast_live & ft_tick & div_hit;
      cpu_run_o     <= cpu_on;
      fast_osc_on_o <= ~slow_s & (mode_q != `PMCS_MODE_DEEP) &
                       (mode_q != `PMCS_MODE_WSLP) & (mode_q != `PMCS_MODE_CLOCK_STOPPED_IDLE_MODE);
      div16_en_o    <= fast_live & ft_tick & (div_q[3:0] == 4'hF);  // see RL8
      div64_en_o    <= fast_live & ft_tick & (div_q == 6'h3F);
      sub_clk_on_o  <= (mode_q != `PMCS_MODE_DEEP);
      wdt_stop_o    <= (mode_q == `PMCS_MODE_DEEP);
      using_sub_o   <= sub_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone read and ack
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
      begin
        case (wb_adr_i)
          `PMCS_ADDR_SYSMODE:
            wb_dat_o <= {24'h000000, system_mode_control_q[7:4], slow_ok, hrdy_q, system_mode_control_q[1:0]};
          `PMCS_ADDR_RSTFLAGS:
            wb_dat_o <= {24'h000000, rflg_q[7], 4'h0, rflg_q[2:0]};
          `PMCS_ADDR_STATUS:
            wb_dat_o <= {25'h0000000, mode_q, 2'h0, tof_q, pdf_q};
          default:
            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/pmcs_chk.sv ***
// Purpose: port-level checks of the clock and power-mode switch
// Assumes: bound into pmcs_top, one clock domain
// Notes:   reset disables every check
`timescale 1ns/10ps
`default_nettype none
module pmcs_chk #(
  parameter HOSC_SEL = 2'h0
) (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        slow_stable_i,
  input wire logic        halt_i,
  input wire logic        cpu_run_o,
  input wire logic        sys_en_o,
  input wire logic        fast_osc_on_o,
  input wire logic        div16_en_o,
  input wire logic        div64_en_o,
  input wire logic        sub_clk_on_o,
  input wire logic        wdt_stop_o,
  input wire logic        using_sub_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_RSVD_ZERO: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h04
    |-> wb_dat_o[6:3] == 4'h0) else $error("unused flag bits read nonzero");
  AST_DIV_STOP: assert property (!fast_osc_on_o |-> !div16_en_o && !div64_en_o)
    else $error("divided clocks run with fast clock off");
  AST_DEEP_STOP: assert property (wdt_stop_o |-> !cpu_run_o && !sys_en_o && !sub_clk_on_o)
    else $error("deep sleep leaves a clock running");
  AST_SUB_ONLY: assert property (using_sub_o |-> HOSC_SEL == 0 && sub_clk_on_o)
    else $error("sub clock wake without crystal or sub clock");
  AST_HALT_STOP: assert property (halt_i && cpu_run_o |-> ##[1:3] !cpu_run_o)
    else $error("halt did not stop the cpu");
  AST_SLOW_OFF: assert property (wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == 8'h00
    && $past(wb_dat_i[7:5]) < 3'h2 && !$past(wb_dat_i[0]) && slow_stable_i
    |-> ##[0:64] !fast_osc_on_o) else $error("fast clock stays on in slow mode");
endmodule
bind pmcs_top pmcs_chk #(.HOSC_SEL(HOSC_SEL)) pmcs_chk_i (.clk_i(clk_i), .reset_i(reset_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_stable_i(slow_stable_i),
  .halt_i(halt_i), .cpu_run_o(cpu_run_o), .sys_en_o(sys_en_o), .fast_osc_on_o(fast_osc_on_o),
  .div16_en_o(div16_en_o), .div64_en_o(div64_en_o), .sub_clk_on_o(sub_clk_on_o),
  .wdt_stop_o(wdt_stop_o), .using_sub_o(using_sub_o));
`default_nettype wire

// *** tb/tb_pmcs_top.sv ***
// Purpose: register and halt-mode sequences for the clock and power-mode switch
// Assumes: crystal fast oscillator, fast tick every 4 clocks, sub tick every 32
// Notes:   expected values come from the register map and mode codes
`timescale 1ns/10ps
`default_nettype none
module tb_pmcs_top;
  logic clk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, halt_i = 0, wake_i = 0;
  logic slow_stable_i = 0, wdt_on_i = 0, wdt_timeout_i = 0, fast_tick_i = 0, slow_tick_i = 0;
  logic [7:0] adr = 8'h00, tc = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic [2:0] rf_ev = 3'h0;
  wire  [31:0] wb_dat_o;
  wire  wb_ack_o, sys_en_o, cpu_run_o, fast_osc_on_o, div16_en_o, sub_clk_on_o, wdt_stop_o, using_sub_o;
  int miscompares = 0, num_checks = 0, n_sys = 0, n_d16 = 0, saw_sub = 0;
  pmcs_top #(.HOSC_SEL(2'h0)) pmcs_top_i (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_tick_i(fast_tick_i), .slow_tick_i(slow_tick_i),
    .slow_stable_i(slow_stable_i), .halt_i(halt_i), .wake_i(wake_i), .wdt_on_i(wdt_on_i),
    .lvd_on_i(1'b0), .wdt_clear_i(1'b0), .wdt_timeout_i(wdt_timeout_i), .lvr_event_i(rf_ev[2]),
    .vcr_bad_i(rf_ev[1]), .wdr_event_i(rf_ev[0]), .sys_en_o(sys_en_o), .cpu_run_o(cpu_run_o),
    .fast_osc_on_o(fast_osc_on_o), .div16_en_o(div16_en_o), .div64_en_o(), .sub_clk_on_o(sub_clk_on_o),
    .wdt_stop_o(wdt_stop_o), .using_sub_o(using_sub_o));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    tc <= tc + 8'h01;
    fast_tick_i <= tc[1];
    slow_tick_i <= tc[4];
    if (sys_en_o === 1'b1) n_sys++;
    if (div16_en_o === 1'b1) n_d16++;
    if (using_sub_o === 1'b1) saw_sub = 1;
  end
  task automatic results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // master holds the request until it samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n == 50) miscompares++;
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  // halt, look at the mode, then wake and wait for the cpu
  task automatic halt_wake(input logic [31:0] st, input int nsys);
    int n;
    halt_i <= 1'b1; wt(1); halt_i <= 1'b0; wt(8);
    n_sys = 0; wt(64);
    chk(cpu_run_o, 1'b0);
    chk(n_sys > 0, nsys);
    wb(0, 8'h08, 0); chk(q, st);
    n = 0; wake_i <= 1'b1;
    while (cpu_run_o !== 1'b1 && n < 3000) begin wt(1); n++; end
    wake_i <= 1'b0;
    chk(cpu_run_o, 1'b1);
    // a fast wake runs on the sub clock until settle; halt is only taken in run
    wt(600);
  endtask
  initial
  begin
    wt(6); reset_i <= 1'b0; wt(1);
    wb(0, 8'h00, 0); chk(q, 32'h01);
    wb(0, 8'h04, 0); chk(q, 32'h00);
    wb(0, 8'h0C, 0); chk(q, 32'h00);
    wt(600); slow_stable_i <= 1'b1; wt(8);
    wb(0, 8'h00, 0); chk(q, 32'h0D);
    for (int i = 0; i < 3; i++)
    begin
      rf_ev <= 3'h1 << i; wt(1); rf_ev <= 3'h0; wt(2);
      wb(1, 8'h04, 32'hFF); wb(0, 8'h04, 0); chk(q, 32'h80 | (1 << i));
      wb(1, 8'h04, 32'h80); wb(0, 8'h04, 0); chk(q, 32'h80);
    end
    wdt_timeout_i <= 1'b1; wt(1); wdt_timeout_i <= 1'b0;
    wb(1, 8'h00, 32'h11); wt(1);
    halt_i <= 1'b1; wt(1); halt_i <= 1'b0; wt(8);
    chk({wdt_stop_o, sub_clk_on_o}, 2'b10);
    wb(0, 8'h08, 0); chk(q, 32'h11);
    wake_i <= 1'b1; wt(1500); wake_i <= 1'b0;
    chk(saw_sub, 0);
    wdt_on_i <= 1'b1; wt(2);
    halt_wake(32'h21, 0);
    chk(saw_sub, 1);
    wb(1, 8'h00, 32'h13);
    halt_wake(32'h41, 1);
    wb(1, 8'h04, 32'h00);
    halt_wake(32'h31, 0);
    wb(1, 8'h00, 32'h20); wt(80);
    chk(fast_osc_on_o, 1'b0);
    n_d16 = 0; wt(300); chk(n_d16, 0);
    wb(1, 8'h00, 32'h40); wt(600);
    chk(fast_osc_on_o, 1'b1);
    wb(0, 8'h00, 0); chk(q[2], 1'b1);
    results;
  end
  initial
  begin
    #400000;
    miscompares++;
    results;
  end
endmodule
`default_nettype wire
